// ===== flash_seq_defines.vh
// constants for the flash self-programming sequencer
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// register select codes on the core write port
`define REG_SEL_CTRL 3'h0
`define REG_SEL_KEY 3'h1
`define REG_SEL_ADDR_LO 3'h2
`define REG_SEL_ADDR_HI 3'h3
`define REG_SEL_SRC_LO 3'h4
`define REG_SEL_SRC_HI 3'h5
// control register fields
`define CTRL_START_BIT 15
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_RESET 16'h0000
// operation codes
`define OP_DWORD 4'h1
`define OP_ROW 4'h2
`define OP_PAGE_ERASE 4'h3
// unlock keys
`define KEY_FIRST 16'h0055
`define KEY_SECOND 16'h00AA
// geometry
`define ROW_WORDS 7'h40
`define ROW_BYTES 12'h0C0
`define PAGE_ROWS 4'h8
`define PAGE_BYTES 12'h600
// program cycle count per word and erase cycle count per row
`define WORD_PROG_CYCLES 16'h0010
`define ERASE_ROW_CYCLES 16'h0020
`endif

// ===== flash_cycle_timer.v
// down counter that times one program or erase step
module flash_cycle_timer (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire load,
  input wire [15:0] count,
  output wire done
);
  reg [15:0] cnt_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= 16'h0000;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end
  assign done = (cnt_q == 16'h0001);
endmodule // flash_cycle_timer

// ===== flash_self_program_sequencer.v
// self-programming sequencer for program flash
//
// Function
// - flash rows hold 64 words of 192 bytes; row write programs one row
// - erase clears one page of eight rows, 512 words
// - pages align to 1536 bytes, rows to 192 bytes from memory start
// - processor is stalled while erase or write runs
// - start bit 15 launches operation; hardware clears it when done
// - double-word write programs two words, only at every other word address
// - row write fetches source words from data RAM at source address
// - key 0x55 then 0xAA must be written before any start
// - unlock key register is write-only; reads return zero
// - upper and lower address registers form one 24-bit address
// - upper register gives bits 23 to 16, lower gives 15 to 0
// - control register selects operation type and holds start bit
// - source low register points to data RAM buffer for row writes
`include "flash_seq_defines.vh"
module flash_self_program_sequencer (
  // clock and reset
  input wire clk,
  input wire rst,
  // core register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [2:0] reg_sel,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // core stall
  output reg cpu_stall,
  // data RAM read port
  output reg ram_rd,
  output reg [15:0] ram_addr,
  input wire [23:0] ram_rdata,
  // flash array port
  output reg flash_prog,
  output reg flash_erase,
  output reg [23:0] flash_addr,
  output reg [23:0] flash_wdata,
  // status
  output reg op_error
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_FETCH = 5'b00010;
  localparam [4:0] ST_PROG = 5'b00100;
  localparam [4:0] ST_ERASE = 5'b01000;
  localparam [4:0] ST_DONE = 5'b10000;

  reg [15:0] ctrl_q;
  reg [7:0] addr_hi_q;
  reg [15:0] addr_lo_q;
  reg [15:0] src_lo_q;
  reg [15:0] src_hi_q;
  reg [1:0] key_q;
  reg [4:0] state_q;
  reg [9:0] idx_q;
  reg [23:0] dw_latch_q;
  reg tload_q;
  reg [15:0] tcount_q;
  wire tdone;
  wire [23:0] eff_addr;
  wire start_req;
  wire [3:0] op;
  reg [15:0] rdata_d;

  ////////////////////////////////////////////////////////////////
  // address join and start qualification
  assign eff_addr = {addr_hi_q, addr_lo_q};
  assign op = ctrl_q[`CTRL_OP_MSB:`CTRL_OP_LSB];
  assign start_req = reg_wr && (reg_sel == `REG_SEL_CTRL) && reg_wdata[`CTRL_START_BIT];

  flash_cycle_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(tload_q),
    .count(tcount_q),
    .done(tdone)
  );

  ////////////////////////////////////////////////////////////////
  // unlock key tracking
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      key_q <= 2'b00;
    else if (reg_wr)
    begin
      if (reg_sel == `REG_SEL_KEY && reg_wdata == `KEY_FIRST)
        key_q <= 2'b01;
      else if (reg_sel == `REG_SEL_KEY && reg_wdata == `KEY_SECOND && key_q == 2'b01)
        key_q <= 2'b10;
      else
        key_q <= 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers and sequencer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `CTRL_RESET;
      addr_hi_q <= 8'h00;
      addr_lo_q <= 16'h0000;
      src_lo_q <= 16'h0000;
      src_hi_q <= 16'h0000;
      state_q <= ST_IDLE;
      idx_q <= 10'h000;
      dw_latch_q <= 24'h000000;
      tload_q <= 1'b0;
      tcount_q <= 16'h0000;
      cpu_stall <= 1'b0;
      ram_rd <= 1'b0;
      ram_addr <= 16'h0000;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr <= 24'h000000;
      flash_wdata <= 24'h000000;
      op_error <= 1'b0;
    end
    else
    begin
      tload_q <= 1'b0;
      ram_rd <= 1'b0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (reg_wr && reg_sel == `REG_SEL_CTRL)
          begin
            ctrl_q <= {1'b0, reg_wdata[14:0]};
            if (start_req)
            begin
              if (key_q != 2'b10)
                op_error <= 1'b1;
              else if (reg_wdata[3:0] == `OP_DWORD && eff_addr[1:0] != 2'b10)
                op_error <= 1'b1;
              else if (reg_wdata[3:0] == `OP_DWORD || reg_wdata[3:0] == `OP_ROW
                       || reg_wdata[3:0] == `OP_PAGE_ERASE)
              begin
                op_error <= 1'b0;
                ctrl_q[`CTRL_START_BIT] <= 1'b1;
                cpu_stall <= 1'b1;
                idx_q <= 10'h000;
                if (reg_wdata[3:0] == `OP_PAGE_ERASE)
                begin
                  flash_addr <= eff_addr - (eff_addr % {12'h000, `PAGE_BYTES});
                  state_q <= ST_ERASE;
                  tload_q <= 1'b1;
                  tcount_q <= `ERASE_ROW_CYCLES;
                end
                else if (reg_wdata[3:0] == `OP_ROW)
                begin
                  flash_addr <= eff_addr - (eff_addr % {12'h000, `ROW_BYTES});
                  ram_addr <= src_lo_q;
                  ram_rd <= 1'b1;
                  state_q <= ST_FETCH;
                end
                else
                begin
                  flash_addr <= eff_addr - 24'h000002;
                  flash_wdata <= dw_latch_q;
                  flash_prog <= 1'b1;
                  tload_q <= 1'b1;
                  tcount_q <= `WORD_PROG_CYCLES;
                  state_q <= ST_PROG;
                end
              end
              else
                op_error <= 1'b1;
            end
          end
          else if (reg_wr && reg_sel == `REG_SEL_ADDR_LO)
            addr_lo_q <= reg_wdata;
          else if (reg_wr && reg_sel == `REG_SEL_ADDR_HI)
            addr_hi_q <= reg_wdata[7:0];
          else if (reg_wr && reg_sel == `REG_SEL_SRC_LO)
            src_lo_q <= reg_wdata;
          else if (reg_wr && reg_sel == `REG_SEL_SRC_HI)
            src_hi_q <= reg_wdata;
        end
        ST_FETCH:
        begin
          flash_wdata <= ram_rdata;
          flash_prog <= 1'b1;
          tload_q <= 1'b1;
          tcount_q <= `WORD_PROG_CYCLES;
          state_q <= ST_PROG;
        end
        ST_PROG:
        begin
          if (tdone)
          begin
            if (op == `OP_ROW && idx_q != {3'h0, `ROW_WORDS} - 10'h001)
            begin
              idx_q <= idx_q + 10'h001;
              flash_addr <= flash_addr + 24'h000002;
              ram_addr <= ram_addr + 16'h0002;
              ram_rd <= 1'b1;
              state_q <= ST_FETCH;
            end
            else if (op == `OP_DWORD && idx_q == 10'h000)
            begin
              idx_q <= 10'h001;
              flash_addr <= flash_addr + 24'h000002;
              flash_prog <= 1'b1;
              tload_q <= 1'b1;
              tcount_q <= `WORD_PROG_CYCLES;
            end
            else
              state_q <= ST_DONE;
          end
        end
        ST_ERASE:
        begin
          if (tdone)
          begin
            if (idx_q != {6'h00, `PAGE_ROWS} - 10'h001)
            begin
              idx_q <= idx_q + 10'h001;
              flash_addr <= flash_addr + {12'h000, `ROW_BYTES};
              flash_erase <= 1'b1;
              tload_q <= 1'b1;
              tcount_q <= `ERASE_ROW_CYCLES;
            end
            else
              state_q <= ST_DONE;
          end
          else if (idx_q == 10'h000 && tcount_q == `ERASE_ROW_CYCLES && !flash_erase
                   && tload_q)
            flash_erase <= 1'b1;
        end
        ST_DONE:
        begin
          ctrl_q[`CTRL_START_BIT] <= 1'b0;
          cpu_stall <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      // data latch for double-word write, taken from source high bits 7:0 and the source low write
      if (state_q == ST_IDLE && reg_wr && reg_sel == `REG_SEL_SRC_LO)
        dw_latch_q <= {src_hi_q[7:0], reg_wdata};
    end
  end

  ////////////////////////////////////////////////////////////////
  // read back
  always @*
  begin
    rdata_d = 16'h0000;
    if (reg_sel == `REG_SEL_CTRL)
      rdata_d = ctrl_q;
    else if (reg_sel == `REG_SEL_KEY)
      rdata_d = 16'h0000;
    else if (reg_sel == `REG_SEL_ADDR_LO)
      rdata_d = addr_lo_q;
    else if (reg_sel == `REG_SEL_ADDR_HI)
      rdata_d = {8'h00, addr_hi_q};
    else if (reg_sel == `REG_SEL_SRC_LO)
      rdata_d = src_lo_q;
    else if (reg_sel == `REG_SEL_SRC_HI)
      rdata_d = src_hi_q;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end
endmodule // flash_self_program_sequencer

// ===== flash_seq_monitor.sv
// port assertions for the flash self-programming sequencer
`include "flash_seq_defines.vh"
module flash_seq_monitor (
  // watched ports
  input wire clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [2:0] reg_sel,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire cpu_stall,
  input wire ram_rd,
  input wire flash_prog,
  input wire flash_erase,
  input wire [23:0] flash_addr,
  input wire op_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic k1_q, k2_q;
  logic [6:0] e_q, p_q;
  wire start_w = reg_wr && reg_sel == `REG_SEL_CTRL && reg_wdata[15];
  // key pair tracking and pulse counts per operation
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      k1_q <= 1'b0;
      k2_q <= 1'b0;
      e_q <= 7'h00;
      p_q <= 7'h00;
    end
    else
    begin
      if (reg_wr)
      begin
        k1_q <= reg_sel == `REG_SEL_KEY && reg_wdata == `KEY_FIRST;
        k2_q <= k1_q && reg_sel == `REG_SEL_KEY && reg_wdata == `KEY_SECOND;
      end
      e_q <= start_w ? 7'h00 : e_q + 7'(flash_erase);
      p_q <= start_w ? 7'h00 : p_q + 7'(flash_prog);
    end
  sequence unlocked_start;
    start_w && k2_q && !cpu_stall;
  endsequence
  locked_start_a:
    assert property (start_w && !k2_q && !cpu_stall |=> !cpu_stall && op_error)
    else $error("start taken without unlock");
  erase_stall_a:
    assert property (unlocked_start ##0 reg_wdata[3:0] == `OP_PAGE_ERASE |=> cpu_stall)
    else $error("erase start did not stall");
  erase_align_a:
    assert property (flash_erase |-> flash_addr % 24'h0000C0 == 24'h000000)
    else $error("erase row not aligned");
  pulse_stall_a:
    assert property (flash_prog || flash_erase || ram_rd |-> cpu_stall)
    else $error("flash activity without stall");
  erase_count_a:
    assert property ($fell(cpu_stall) |-> e_q == 7'h00 || e_q == 7'h08)
    else $error("wrong erase row count");
  prog_count_a:
    assert property ($fell(cpu_stall) |-> p_q == 7'h00 || p_q == 7'h02 || p_q == 7'h40)
    else $error("wrong program word count");
  fetch_prog_a:
    assert property (ram_rd |-> ##[1:40] flash_prog)
    else $error("fetch not followed by program");
  key_read_a:
    assert property (reg_rd && reg_sel == `REG_SEL_KEY |=> reg_rdata == 16'h0000)
    else $error("key register readable");
  start_clear_a:
    assert property (reg_rd && reg_sel == `REG_SEL_CTRL && !cpu_stall && !start_w
      |=> !reg_rdata[15])
    else $error("start bit set while idle");
endmodule // flash_seq_monitor
bind flash_self_program_sequencer flash_seq_monitor flash_seq_monitor_i (.clk, .rst,
  .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .cpu_stall, .ram_rd,
  .flash_prog, .flash_erase, .flash_addr, .op_error);

// ===== data_ram_model.sv
// data RAM model answering the sequencer's source fetches
module data_ram_model (
  // clock and fetch port
  input wire clk,
  input wire ram_rd,
  input wire [15:0] ram_addr,
  output wire [23:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] churn_q = 24'h000000;
  // churn between fetches so a mistimed sample shows up
  always @(posedge clk)
    churn_q <= ~churn_q;
  // the sequencer takes the word at the edge that ends the ram_rd cycle
  assign ram_rdata = ram_rd ? {8'h5A, ram_addr} : churn_q;
endmodule // data_ram_model

// ===== tb_flash_self_program_sequencer.sv
// testbench for the flash self-programming sequencer
`include "flash_seq_defines.vh"
module tb_flash_self_program_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, reg_wr, reg_rd;
  logic [2:0] reg_sel;
  logic [15:0] reg_wdata;
  wire [15:0] reg_rdata, ram_addr;
  wire cpu_stall, ram_rd, flash_prog, flash_erase, op_error;
  wire [23:0] ram_rdata, flash_addr, flash_wdata;
  int errors, samples_checked, n_p, n_e;
  logic [23:0] a0, a1, d0;
  flash_self_program_sequencer flash_self_program_sequencer_i (.clk, .rst, .reg_wr,
    .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .cpu_stall, .ram_rd, .ram_addr,
    .ram_rdata, .flash_prog, .flash_erase, .flash_addr, .flash_wdata, .op_error);
  data_ram_model data_ram_model_i (.clk, .ram_rd, .ram_addr, .ram_rdata);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic watch;
    n_p = 0;
    n_e = 0;
    for (int i = 0; i < 3000; i++)
    begin
      if (flash_prog)
      begin
        if (n_p == 0)
          d0 = flash_wdata;
        if (n_p == 0)
          a0 = flash_addr;
        a1 = flash_addr;
        n_p++;
      end
      if (flash_erase && n_e++ == 0)
        a0 = flash_addr;
      if (!cpu_stall && i > 0)
        return;
      @(negedge clk);
    end
    chk(24'h0, 24'h1, "stall never ended");
    finish_test;
  endtask
  task automatic go(input logic [23:0] a, input logic [15:0] s, input logic [3:0] op,
    input int k);
    wr(`REG_SEL_ADDR_HI, {8'h00, a[23:16]});
    wr(`REG_SEL_ADDR_LO, a[15:0]);
    wr(`REG_SEL_SRC_LO, s);
    wr(`REG_SEL_SRC_HI, 16'h0000);
    if (k > 0)
      wr(`REG_SEL_KEY, `KEY_FIRST);
    if (k > 1)
      wr(`REG_SEL_SRC_HI, 16'h0000);
    if (k > 0)
      wr(`REG_SEL_KEY, `KEY_SECOND);
    wr(`REG_SEL_CTRL, {12'h800, op});
    watch;
  endtask
  task automatic refused(input string m);
    chk(24'(op_error), 24'h1, m);
    chk(24'(n_p + n_e), 24'h0, m);
  endtask
  task automatic t_refuse;
    go(24'h010700, 16'h0, `OP_PAGE_ERASE, 0);
    refused("no key");
    go(24'h010700, 16'h0, `OP_PAGE_ERASE, 2);
    refused("broken key");
    go(24'h000004, 16'h0, `OP_DWORD, 1);
    refused("odd pair");
    go(24'h000000, 16'h0, 4'h4, 1);
    refused("bad op");
    $display("done: refuse");
  endtask
  task automatic t_erase;
    go(24'h010700, 16'h0, `OP_PAGE_ERASE, 1);
    chk(24'(op_error), 24'h0, "erase error");
    chk(24'(n_e), 24'h8, "erase rows");
    chk(a0, 24'h010700 - 24'h010700 % 24'h000600, "page base");
    @(negedge clk);
    reg_rd = 1;
    reg_sel = `REG_SEL_CTRL;
    @(negedge clk);
    reg_rd = 0;
    chk(24'(reg_rdata[15]), 24'h0, "start bit");
    $display("done: erase");
  endtask
  task automatic t_write;
    go(24'h000000, 16'h0, `OP_PAGE_ERASE, 1);
    chk(24'(n_e), 24'h8, "pre-erase rows");
    go(24'h000006, 16'h0300, `OP_DWORD, 1);
    chk(24'(n_p), 24'h2, "pair count");
    chk(a0, 24'h000004, "pair first");
    chk(a1, 24'h000006, "pair second");
    chk(d0, 24'h000300, "pair data");
    go(24'h0001C0, 16'h0200, `OP_ROW, 1);
    chk(24'(n_p), 24'h40, "row count");
    chk(a0, 24'h000180, "row base");
    chk(a1, 24'h0001FE, "row end");
    chk(d0, 24'h5A0200, "row data");
    @(negedge clk);
    reg_rd = 1;
    reg_sel = `REG_SEL_KEY;
    @(negedge clk);
    reg_rd = 0;
    chk(24'(reg_rdata), 24'h0, "key read");
    $display("done: write");
  endtask
  ////////////////////////////////////////
  initial
  begin
    errors = 0;
    samples_checked = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_sel = 3'h0;
    reg_wdata = 16'h0000;
    rst = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    t_refuse;
    t_erase;
    t_write;
    finish_test;
  end
endmodule // tb_flash_self_program_sequencer
